// ### core/pwg_regs.vh
/*
 * Constants for the periodic FIFO waveform generator: APB register
 * offsets, field positions, reset values and default sizes.
 * Assumes a 32-bit APB bus with word-aligned byte addresses.
 */
// Contract
// RL1 - FIFO makes its own addresses and drives full, empty, almost flags.
// RL2 - with write halt on, write counter stops while full.
// RL3 - with read halt on, read counter stops once empty.
// RL4 - with read halt off, read counter wraps from last entry to zero.
// RL5 - in wrap mode empty pulses one cycle at last entry, clears on wrap.
// RL6 - loader fills the FIFO once before replay; no writes after.
// RL7 - write and read ports differ in width; one write holds several samples.
// RL8 - half-cycle pattern is read twice per full output period.
// RL9 - output stage reads only once enabled after initialisation ends.
// RL10 - active-low read enable low when enabled and out of reset.
// RL11 - sign toggles on each edge where enable and empty are both high.
// RL12 - each edge registers nine-bit word: sign above eight-bit sample.
// RL13 - reset forces positive half, sign zero, output word zero.
// RL14 - wrap mode selected by clearing the read halt configuration bit.
// RL15 - in wrap mode read counter moves only when read enable is active.
`ifndef PWG_REGS_VH
`define PWG_REGS_VH

// register byte offsets
`define PWG_CTRL_OFS 12'h000
`define PWG_STAT_OFS 12'h004
`define PWG_IRQ_STAT_OFS 12'h008
`define PWG_IRQ_MASK_OFS 12'h00C
`define PWG_WDATA_OFS 12'h010
`define PWG_LEVEL_OFS 12'h014

// control fields
`define PWG_CTRL_WHALT 0
`define PWG_CTRL_RHALT 1
`define PWG_CTRL_ENABLE 2
`define PWG_CTRL_RESET_VAL 3'h3

// status and interrupt fields
`define PWG_ST_FULL 0
`define PWG_ST_EMPTY 1
`define PWG_ST_ALMOST_FULL_FLAG 2
`define PWG_ST_ALMOST_EMPTY_FLAG 3
`define PWG_ST_SIGN 4
`define PWG_IRQ_WRAP 0
`define PWG_IRQ_FULL 1
`define PWG_IRQ_OVF 2

// default sizes and thresholds
`define PWG_RD_WIDTH 8
`define PWG_WR_WIDTH 32
`define PWG_RD_AW 10
`define PWG_ALMOST_FULL_FLAG_GAP 16
`define PWG_ALMOST_EMPTY_FLAG_LVL 16

`endif

// ### core/pwg_mem.v
/*
 * Dual-ported sample memory: wide write port, narrow registered read.
 * Assumes one clock; write width is RATIO times read width.
 */
`timescale 1ns/1ps
`default_nettype none
module pwg_mem #(
    parameter RD_W = 8,
    parameter RATIO = 4,
    parameter RD_AW = 10,
    parameter WR_AW = 8
) (
    // clock
    input wire clk_in,
    // wide write port
    input wire wr_en_in,
    input wire [WR_AW-1:0] wr_addr_in,
    input wire [RD_W*RATIO-1:0] wr_data_in,
    // narrow read port
    input wire rd_en_in,
    input wire [RD_AW-1:0] rd_addr_in,
    output reg [RD_W-1:0] rd_data_out
);
    reg [RD_W-1:0] mem [0:(1<<RD_AW)-1];
    genvar g;

    // one write stores RATIO samples, lowest lane at lowest address
    generate
        for (g = 0; g < RATIO; g = g + 1) begin : lane
            // lane index sized to the low address bits; a genvar has no bits
            localparam [RD_AW-WR_AW-1:0] LANE = g;
            always @(posedge clk_in) begin
                if (wr_en_in) begin
                    mem[{wr_addr_in, LANE}] <=
                        wr_data_in[g*RD_W +: RD_W];
                end
            end
        end
    endgenerate

    // registered read
    always @(posedge clk_in) begin
        if (rd_en_in) begin
            rd_data_out <= mem[rd_addr_in];
        end
    end
endmodule
`default_nettype wire

// ### core/pwg_top.v
/*
 * Periodic FIFO waveform generator: FIFO controller with wrap-mode read
 * counter, sign-flipping output stage and APB register slave.
 * Assumes one 100 MHz clock, synchronous active-high reset, and a
 * loader that fills the FIFO once over APB before setting enable.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pwg_regs.vh"
module pwg_top #(
    parameter RD_W = `PWG_RD_WIDTH,
    parameter RATIO = `PWG_WR_WIDTH / `PWG_RD_WIDTH,
    parameter RD_AW = `PWG_RD_AW,
    parameter WR_AW = 8,
    parameter ALMOST_FULL_FLAG_GAP = `PWG_ALMOST_FULL_FLAG_GAP,
    parameter ALMOST_EMPTY_FLAG_LVL = `PWG_ALMOST_EMPTY_FLAG_LVL
) (
    // clock and reset
    input wire CLOCK_IN,
    input wire SYS_RST_IN,
    // apb slave
    input wire PSEL_IN,
    input wire PENABLE_IN,
    input wire PWRITE_IN,
    input wire [11:0] PADDR_IN,
    input wire [31:0] PWDATA_IN,
    output reg [31:0] PRDATA_OUT,
    output wire PREADY_OUT,
    output wire PSLVERR_OUT,
    // fifo flags
    output wire FULL_OUT,
    output wire EMPTY_OUT,
    output wire ALMOST_FULL_FLAG_OUT,
    output wire ALMOST_EMPTY_FLAG_OUT,
    // converter side
    output wire READ_EN_N_OUT,
    output reg [RD_W:0] WAVE_OUT,
    // interrupt
    output wire IRQ_OUT
);
    localparam DEPTH = 1 << RD_AW;
    localparam WDEPTH = 1 << WR_AW;

    ////////////////////////////////////////////////////////////////////
    // apb decode

    wire apb_acc = PSEL_IN & PENABLE_IN;
    wire apb_wr = apb_acc & PWRITE_IN;
    wire ofs_ok = (PADDR_IN == `PWG_CTRL_OFS) |
        (PADDR_IN == `PWG_STAT_OFS) | (PADDR_IN == `PWG_IRQ_STAT_OFS) |
        (PADDR_IN == `PWG_IRQ_MASK_OFS) | (PADDR_IN == `PWG_WDATA_OFS) |
        (PADDR_IN == `PWG_LEVEL_OFS);

    // always zero wait states; unmapped address flags an error
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = apb_acc & ~ofs_ok;

    ////////////////////////////////////////////////////////////////////
    // control register

    reg [2:0] ctrl_reg;
    wire write_halt_on_full = ctrl_reg[`PWG_CTRL_WHALT];
    wire read_halt_on_empty = ctrl_reg[`PWG_CTRL_RHALT];
    wire enable = ctrl_reg[`PWG_CTRL_ENABLE];

    // software picks halt/wrap and end-of-initialisation enable
    always @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            ctrl_reg <= `PWG_CTRL_RESET_VAL;
        end else if (apb_wr && PADDR_IN == `PWG_CTRL_OFS) begin
            ctrl_reg <= PWDATA_IN[2:0]; // RL14
        end
    end

    ////////////////////////////////////////////////////////////////////
    // fifo controller: counters and level

    reg [WR_AW-1:0] wr_ptr_reg;
    reg [RD_AW-1:0] rd_ptr_reg;
    reg [RD_AW:0] level_reg;
    reg [RD_AW:0] level_next;
    wire full = (level_reg == DEPTH); // RL1
    wire last_pos = (rd_ptr_reg == DEPTH - 1);
    wire wr_req = apb_wr && PADDR_IN == `PWG_WDATA_OFS;
    wire wr_go;
    wire rd_go;
    wire rd_en = enable & ~SYS_RST_IN;
    reg empty;

    // wide write blocked at full when halt is on; ignored otherwise too
    // when no room for a whole word, so a level never overflows
    wire room = (level_reg <= DEPTH - RATIO);
    assign wr_go = wr_req & room & ~(write_halt_on_full & full); // RL2

    // empty: halt mode true on level zero; wrap mode one cycle at last
    always @* begin
        if (read_halt_on_empty) begin
            empty = (level_reg == 0); // RL3
        end else begin
            empty = last_pos & rd_en; // RL5
        end
    end

    // read advances only on read enable; halt mode stops at empty
    assign rd_go = rd_en & ~(read_halt_on_empty & empty); // RL15

    // write pointer counts words, read pointer counts samples
    always @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            wr_ptr_reg <= {WR_AW{1'b0}};
        end else if (wr_go) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1; // RL7
        end
    end

    // natural overflow of the counter wraps last entry back to zero
    always @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            rd_ptr_reg <= {RD_AW{1'b0}};
        end else if (rd_go) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1; // RL4
        end
    end

    // level only drops in halt mode; replay keeps the pattern intact
    always @* begin
        level_next = level_reg;
        if (wr_go) begin
            level_next = level_next + RATIO[RD_AW:0];
        end
        if (rd_go && read_halt_on_empty) begin
            level_next = level_next - 1'b1;
        end
    end

    always @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            level_reg <= {(RD_AW+1){1'b0}};
        end else begin
            level_reg <= level_next;
        end
    end

    assign FULL_OUT = full; // RL1
    assign EMPTY_OUT = empty; // RL1
    assign ALMOST_FULL_FLAG_OUT = (level_reg >= DEPTH - ALMOST_FULL_FLAG_GAP); // RL1
    assign ALMOST_EMPTY_FLAG_OUT = (level_reg <= ALMOST_EMPTY_FLAG_LVL); // RL1

    ////////////////////////////////////////////////////////////////////
    // sample memory

    wire [RD_W-1:0] sample;

    pwg_mem #(
        .RD_W(RD_W),
        .RATIO(RATIO),
        .RD_AW(RD_AW),
        .WR_AW(WR_AW)
    ) u_mem (
        .clk_in(CLOCK_IN),
        .wr_en_in(wr_go),
        .wr_addr_in(wr_ptr_reg),
        .wr_data_in(PWDATA_IN[RD_W*RATIO-1:0]),
        .rd_en_in(rd_go),
        .rd_addr_in(rd_ptr_reg),
        .rd_data_out(sample)
    );

    ////////////////////////////////////////////////////////////////////
    // output stage

    localparam POS_HALF = 1'b0;
    localparam NEG_HALF = 1'b1;
    reg state_reg;
    reg state_next;
    reg sign_reg;
    reg sign_next;

    // read strobe only while enabled and out of reset
    assign READ_EN_N_OUT = ~rd_en; // RL10 RL9

    // next half and its sign
    always @* begin
        case (state_reg)
            POS_HALF: begin
                state_next = NEG_HALF;
                sign_next = 1'b1;
            end
            NEG_HALF: begin
                state_next = POS_HALF;
                sign_next = 1'b0;
            end
            default: begin
                state_next = POS_HALF;
                sign_next = 1'b0;
            end
        endcase
    end

    // empty marks the end of each pass, so two passes make a period
    always @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            state_reg <= POS_HALF; // RL13
            sign_reg <= 1'b0;
        end else if (enable && empty) begin
            state_reg <= state_next; // RL11 RL8
            sign_reg <= sign_next;
        end
    end

    // output word: sign above sample
    always @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            WAVE_OUT <= {(RD_W+1){1'b0}}; // RL13
        end else begin
            WAVE_OUT <= {sign_reg, sample}; // RL12
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupts

    reg [2:0] irq_stat_reg;
    reg [2:0] irq_mask_reg;
    wire [2:0] irq_ev = {wr_req & ~wr_go, wr_go & (level_next == DEPTH),
        enable & empty & ~read_halt_on_empty};
    wire stat_wr = apb_wr && PADDR_IN == `PWG_IRQ_STAT_OFS;

    // sticky bits; a new event beats a write-one clear
    always @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            irq_stat_reg <= 3'h0;
        end else begin
            irq_stat_reg <= (irq_stat_reg &
                ~(stat_wr ? PWDATA_IN[2:0] : 3'h0)) | irq_ev;
        end
    end

    always @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            irq_mask_reg <= 3'h0;
        end else if (apb_wr && PADDR_IN == `PWG_IRQ_MASK_OFS) begin
            irq_mask_reg <= PWDATA_IN[2:0];
        end
    end

    assign IRQ_OUT = |(irq_stat_reg & irq_mask_reg);

    ////////////////////////////////////////////////////////////////////
    // read data mux

    always @* begin
        PRDATA_OUT = 32'h0000_0000;
        case (PADDR_IN)
            `PWG_CTRL_OFS: PRDATA_OUT[2:0] = ctrl_reg;
            `PWG_STAT_OFS: PRDATA_OUT[4:0] = {sign_reg,
                ALMOST_EMPTY_FLAG_OUT, ALMOST_FULL_FLAG_OUT, empty, full};
            `PWG_IRQ_STAT_OFS: PRDATA_OUT[2:0] = irq_stat_reg;
            `PWG_IRQ_MASK_OFS: PRDATA_OUT[2:0] = irq_mask_reg;
            `PWG_LEVEL_OFS: PRDATA_OUT[RD_AW:0] = level_reg;
            default: PRDATA_OUT = 32'h0000_0000;
        endcase
    end
endmodule
`default_nettype wire

// ### dv/pwg_checker.sv
/* Port checker for the waveform generator.
   Assumes binding into pwg_top, one clock, sync active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module pwg_checker #(parameter RD_W = 8) (
    // clock and reset
    input wire logic CLOCK_IN,
    input wire logic SYS_RST_IN,
    // apb request
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    // flags and stream
    input wire logic FULL_OUT,
    input wire logic EMPTY_OUT,
    input wire logic ALMOST_FULL_FLAG_OUT,
    input wire logic ALMOST_EMPTY_FLAG_OUT,
    input wire logic READ_EN_N_OUT,
    input wire logic [RD_W:0] WAVE_OUT
);
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (SYS_RST_IN);
    // enabled stream meets the last entry
    sequence s_turn;
        EMPTY_OUT && !READ_EN_N_OUT;
    endsequence
    // control write seen one edge earlier
    sequence s_ctrl_wr;
        $past(PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN == 12'h000);
    endsequence
    a_ren_reset: assert property (disable iff (1'b0)
        SYS_RST_IN |-> READ_EN_N_OUT) else $error("read enable in reset");
    a_wave_reset: assert property (disable iff (1'b0)
        SYS_RST_IN |=> WAVE_OUT == '0) else $error("word not cleared");
    a_sign_flip: assert property (s_turn |=> ##1
        WAVE_OUT[RD_W] != $past(WAVE_OUT[RD_W])) else $error("no flip");
    a_sign_hold: assert property (!(EMPTY_OUT && !READ_EN_N_OUT)
        |=> ##1 $stable(WAVE_OUT[RD_W])) else $error("stray flip");
    a_ren_start: assert property ($fell(READ_EN_N_OUT) |-> s_ctrl_wr)
        else $error("read started without enable");
    a_ren_stop: assert property ($rose(READ_EN_N_OUT) |-> s_ctrl_wr)
        else $error("read stopped without cause");
    a_full_almost_full_flag: assert property (FULL_OUT |-> ALMOST_FULL_FLAG_OUT)
        else $error("full without almost full");
    a_full_almost_empty_flag: assert property (
        FULL_OUT |-> !ALMOST_EMPTY_FLAG_OUT) else $error("full and almost_empty_flag");
endmodule
bind pwg_top pwg_checker #(.RD_W(RD_W)) u_chk (.CLOCK_IN(CLOCK_IN),
    .SYS_RST_IN(SYS_RST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
    .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .FULL_OUT(FULL_OUT),
    .EMPTY_OUT(EMPTY_OUT), .ALMOST_FULL_FLAG_OUT(ALMOST_FULL_FLAG_OUT),
    .ALMOST_EMPTY_FLAG_OUT(ALMOST_EMPTY_FLAG_OUT),
    .READ_EN_N_OUT(READ_EN_N_OUT), .WAVE_OUT(WAVE_OUT));
`default_nettype wire

// ### dv/pwg_dac_model.sv
/* Converter model: takes one nine-bit word per cycle.
   Assumes a pattern of 1..DEPTH in the fifo. */
`timescale 1ns/1ps
`default_nettype none
module pwg_dac_model #(parameter DEPTH = 16) (
    input wire logic clk_in,
    input wire logic [8:0] wave_in,
    input wire logic read_en_n_in,
    output int taken_out,
    output int jumps_out
);
    logic [2:0] run = '0;
    logic [7:0] last = '0;
    initial taken_out = 0;
    initial jumps_out = 0;
    // skip three edges after start: the read pipeline refills first
    always @(posedge clk_in) begin
        run <= {run[1:0], ~read_en_n_in};
        last <= wave_in[7:0];
        if (&run) begin
            taken_out <= taken_out + 1;
            // sample must follow on, wrapping after the last entry
            if (wave_in[7:0] != ((last == DEPTH) ? 8'h01 : last + 8'h01))
                jumps_out <= jumps_out + 1;
        end
    end
endmodule
`default_nettype wire

// ### dv/periodic_fifo_waveform_gen_test.sv
/* Self-checking bench for the waveform generator.
   Assumes pwg_top, its bound checker and the converter model. */
`timescale 1ns/1ps
`default_nettype none
module periodic_fifo_waveform_gen_test;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, err, s;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic pready, perr, full, empty, almost_full_flag, almost_empty_flag, ren_n, irq, rdy;
    logic [8:0] wave, hold;
    int bad_count = 0, cmp_count = 0, taken, jumps, i, n;
    // 16-entry fifo keeps every pass short
    pwg_top #(.RD_AW(4), .WR_AW(2), .ALMOST_FULL_FLAG_GAP(4), .ALMOST_EMPTY_FLAG_LVL(4)) DUT (
        .CLOCK_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(perr), .FULL_OUT(full), .EMPTY_OUT(empty),
        .ALMOST_FULL_FLAG_OUT(almost_full_flag), .ALMOST_EMPTY_FLAG_OUT(almost_empty_flag),
        .READ_EN_N_OUT(ren_n), .WAVE_OUT(wave), .IRQ_OUT(irq));
    pwg_dac_model dac (.clk_in(clk), .wave_in(wave),
        .read_en_n_in(ren_n), .taken_out(taken), .jumps_out(jumps));
    always #5 clk = ~clk;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    // one apb transfer, held until pready is seen
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1;
        n = 0;
        // answer taken mid access cycle, request held through its edge
        do begin
            @(negedge clk);
            rdy = pready;
            r = prdata;
            err = perr;
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        if (rdy !== 1'b1) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, rdy, 1);
        end
        psel <= 0;
        pen <= 0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk(r, e);
    endtask
    ////////////////////////////////////////////////////////////////////
    task t_reset;
        repeat (10) @(posedge clk);
        chk(ren_n, 1);
        chk(wave, 0);
        rst <= 0;
        rd(12'h000, 32'h3);
        rd(12'h014, 32'h0);
        chk(empty, 1);
        apb(0, 12'h020, 0);
        chk(err, 1);
        $display("reset test done");
    endtask
    task t_load;
        for (i = 0; i < 4; i++)
            apb(1, 12'h010, {8'(4*i+4), 8'(4*i+3), 8'(4*i+2), 8'(4*i+1)});
        @(negedge clk);
        chk(full, 1);
        chk(almost_full_flag, 1);
        rd(12'h014, 32'h10);
        rd(12'h008, 32'h2);
        apb(1, 12'h010, 32'hFFFFFFFF);
        rd(12'h014, 32'h10);
        rd(12'h008, 32'h6);
        apb(1, 12'h00C, 32'h4);
        @(negedge clk);
        chk(irq, 1);
        apb(1, 12'h008, 32'h6);
        @(negedge clk);
        chk(irq, 0);
        $display("load test done");
    endtask
    task t_wrap;
        apb(1, 12'h000, 32'h4);
        n = 0;
        while (empty !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        s = wave[8];
        n = 0;
        i = 0;
        repeat (40) begin
            @(negedge clk);
            n += empty;
            i += (wave[8] != s);
            s = wave[8];
        end
        chk(n, 2);
        chk(i, 3);
        apb(0, 12'h008, 0);
        chk(r[0], 1);
        $display("wrap test done");
    endtask
    task t_pause;
        apb(1, 12'h000, 32'h0);
        @(negedge clk);
        chk(ren_n, 1);
        repeat (3) @(negedge clk);
        hold = wave;
        repeat (5) @(negedge clk);
        chk(wave, hold);
        apb(1, 12'h000, 32'h4);
        repeat (20) @(posedge clk);
        chk(jumps, 0);
        chk(taken > 30, 1);
        $display("pause test done");
    endtask
    task t_halt;
        apb(1, 12'h000, 32'h6);
        repeat (40) @(posedge clk);
        @(negedge clk);
        chk(empty, 1);
        chk(almost_empty_flag, 1);
        rd(12'h014, 32'h0);
        $display("halt test done");
    endtask
    task close_out;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        t_reset;
        t_load;
        t_wrap;
        t_pause;
        t_halt;
        close_out;
    end
    // whole run is some 200 cycles; cut a hang well beyond that
    initial begin
        #20000;
        bad_count++;
        close_out;
    end
endmodule
`default_nettype wire
